/* rtl/tdb_pkg.sv */
// tdb_pkg: constants shared by the timer capture/compare and burst register slice.
// assumes: byte addressing on a 32-bit register bus, one aligned word per register.
package tdb_pkg;

    // widths
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned NCHAN = 4;
    localparam int unsigned FIELD5_W = 5;
    localparam int unsigned REMAP_W = 2;
    localparam int unsigned BE_W = 4;

    // register byte offsets
    localparam logic [7:0] OFS_CTL0 = 8'h00;
    localparam logic [7:0] OFS_CCV0 = 8'h34;
    localparam logic [7:0] OFS_CCV1 = 8'h38;
    localparam logic [7:0] OFS_CCV2 = 8'h3c;
    localparam logic [7:0] OFS_CCV3 = 8'h40;
    localparam logic [7:0] OFS_IRMP = 8'h50;
    localparam logic [7:0] OFS_BCFG = 8'he0;
    localparam logic [7:0] OFS_BBUF = 8'he4;
    localparam logic [7:0] WORD_BYTES = 8'h04;

    // field positions of the burst configuration register
    localparam int unsigned BCFG_START_LSB = 0;
    localparam int unsigned BCFG_START_MSB = 4;
    localparam int unsigned BCFG_COUNT_LSB = 8;
    localparam int unsigned BCFG_COUNT_MSB = 12;

    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_HALF = 16'h0000;
    localparam logic [4:0] RST_FIELD5 = 5'h00;
    localparam logic [1:0] RST_REMAP = 2'h0;

    // full-word byte enable
    localparam logic [3:0] BE_FULL = 4'hf;

    // channel 0 input selections
    localparam logic [1:0] SEL_GPIO = 2'h0;
    localparam logic [1:0] SEL_LOW_CRYSTAL = 2'h1;
    localparam logic [1:0] SEL_HIGH_CRYSTAL_DIV128 = 2'h2;
    localparam logic [1:0] SEL_CKOUT = 2'h3;

    // bus slave states
    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_ACK
    } tdb_bus_e;

endpackage

/* rtl/tdb_chan.sv */
// tdb_chan: one capture/compare channel value with preload and active copies.
// assumes: mode, shadow enable, capture and update come synchronous from the timer core.
`timescale 1ns/10ps
module tdb_chan (
    input wire logic clk,
    input wire logic reset,
    input wire logic input_mode,
    input wire logic shadow_en,
    input wire logic capture,
    input wire logic update,
    input wire logic [tdb_pkg::CNT_W-1:0] counter,
    input wire logic wr_en,
    input wire logic [tdb_pkg::CNT_W-1:0] wr_data,
    output logic [tdb_pkg::CNT_W-1:0] rd_value,
    output logic match
);
    import tdb_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] preload;
        logic [CNT_W-1:0] active;
        logic match;
    } tdb_chan_s;

    tdb_chan_s q, d;

    // next state: capture in input mode, preload/shadow transfer in output mode
    always_comb begin
        d = q;
        if (input_mode) begin
            // software writes are dropped here, the field belongs to hardware
            if (capture) begin
                d.preload = counter;
                d.active = counter;
            end
        end else begin
            if (wr_en) begin
                d.preload = wr_data;
                if (!shadow_en) begin
                    d.active = wr_data;
                end
            end
            // update takes the preload as it stood, a same-cycle write waits one event
            if (update && shadow_en) begin
                d.active = q.preload;
            end
        end
        d.match = !input_mode && (counter == q.active);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rd_value = input_mode ? q.active : q.preload;
    assign match = q.match;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_capture_load: assert property (input_mode && capture |=> q.active == $past(counter))
        else $error("captured value not loaded");
    a_input_readonly: assert property (input_mode && !capture && wr_en
        |=> $stable(q.preload))
        else $error("write changed channel in input mode");
    // the reset-release edge is left out: match is still held low by reset there
    a_compare_match: assert property (!reset && !input_mode && counter == q.active
        |=> match)
        else $error("compare match missing");
    a_shadow_hold: assert property (!input_mode && shadow_en && !update
        |=> $stable(q.active))
        else $error("active compare changed without update");
    a_shadow_load: assert property (!input_mode && shadow_en && update
        |=> q.active == $past(q.preload))
        else $error("update did not load active compare");

endmodule // tdb_chan

/* rtl/tdb_burst.sv */
// tdb_burst: transfer index of the burst buffer and the byte address it redirects to.
// assumes: step pulses once per completed buffer access.
`timescale 1ns/10ps
module tdb_burst (
    input wire logic clk,
    input wire logic reset,
    input wire logic [tdb_pkg::FIELD5_W-1:0] start,
    input wire logic [tdb_pkg::FIELD5_W-1:0] count,
    input wire logic step,
    output logic [tdb_pkg::FIELD5_W-1:0] index,
    output logic [tdb_pkg::ADDR_W-1:0] target
);
    import tdb_pkg::*;

    typedef struct packed {
        logic [FIELD5_W-1:0] index;
    } tdb_burst_s;

    tdb_burst_s q, d;
    logic [5:0] word_sum;

    // index walks 0..count, then wraps; >= also recovers if count was lowered mid-burst
    always_comb begin
        d = q;
        if (step) begin
            if (q.index >= count) begin
                d.index = RST_FIELD5;
            end else begin
                d.index = q.index + 5'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // control register 0 plus four bytes per word of start and index
    assign word_sum = {1'b0, start} + {1'b0, q.index};
    assign target = OFS_CTL0 + {word_sum, 2'b00};
    assign index = q.index;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_index_step: assert property (step && q.index < count
        |=> q.index == $past(q.index) + 5'h01)
        else $error("transfer index did not advance");
    a_index_wrap: assert property (step && q.index >= count |=> q.index == 5'h00)
        else $error("transfer index did not return to zero");
    a_index_idle: assert property (!step |=> $stable(q.index))
        else $error("transfer index moved without access");

endmodule // tdb_burst

/* rtl/tdb_top.sv */
// tdb_top: capture/compare values, burst access buffer and channel 0 input remap,
// reached over an Avalon-MM slave with waitrequest.
// assumes: counter, capture, update, mode and shadow controls come from the timer core,
// all synchronous to clk; the DMA controller and the processor share this one slave port.
`timescale 1ns/10ps
module tdb_top (
    input wire logic clk,
    input wire logic reset,
    input wire logic [tdb_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [tdb_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [tdb_pkg::BE_W-1:0] avs_byteenable,
    output logic [tdb_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [tdb_pkg::CNT_W-1:0] counter_value,
    input wire logic update_event,
    input wire logic [tdb_pkg::NCHAN-1:0] chan_input_mode,
    input wire logic [tdb_pkg::NCHAN-1:0] chan_shadow_en,
    input wire logic [tdb_pkg::NCHAN-1:0] capture_event,
    input wire logic pin_gpio_ch0,
    input wire logic low_speed_crystal,
    input wire logic high_speed_crystal_div128,
    input wire logic clock_output_selection,
    output logic [tdb_pkg::NCHAN-1:0] compare_match,
    output logic chan0_input
);
    import tdb_pkg::*;

    typedef struct packed {
        tdb_bus_e state;
        logic waitreq;
        logic [DATA_W-1:0] rdata;
        logic [REMAP_W-1:0] remap;
        logic [FIELD5_W-1:0] bstart;
        logic [FIELD5_W-1:0] bcount;
        logic ch0in;
    } tdb_top_s;

    tdb_top_s q, d;

    logic req;
    logic commit;
    logic wr_ok;
    logic step;
    logic [ADDR_W-1:0] eff_addr;
    logic [ADDR_W-1:0] burst_target;
    logic [FIELD5_W-1:0] burst_index;
    logic [NCHAN-1:0][CNT_W-1:0] chan_rd;
    logic [NCHAN-1:0] chan_wr;
    logic [DATA_W-1:0] rd_mux;

    // the master holds its request through the ack cycle, so commit there
    assign req = avs_read || avs_write;
    assign commit = (q.state == BUS_ACK) && req;
    // partial-lane writes are dropped: a torn compare value would glitch the output
    assign wr_ok = commit && avs_write && (avs_byteenable == BE_FULL);
    assign step = commit && (avs_address == OFS_BBUF);

    // buffer accesses are redirected into the register map
    always_comb begin
        if (avs_address == OFS_BBUF) begin
            eff_addr = burst_target;
        end else begin
            eff_addr = avs_address;
        end
    end

    // transfer index and redirect address
    tdb_burst u_burst (
        .clk(clk),
        .reset(reset),
        .start(q.bstart),
        .count(q.bcount),
        .step(step),
        .index(burst_index),
        .target(burst_target)
    );

    // four identical channels, each at its own word
    for (genvar g = 0; g < NCHAN; g++) begin : g_chan
        localparam logic [7:0] CH_OFS = OFS_CCV0 + WORD_BYTES * 8'(g);
        assign chan_wr[g] = wr_ok && (eff_addr == CH_OFS);
        tdb_chan u_chan (
            .clk(clk),
            .reset(reset),
            .input_mode(chan_input_mode[g]),
            .shadow_en(chan_shadow_en[g]),
            .capture(capture_event[g]),
            .update(update_event),
            .counter(counter_value),
            .wr_en(chan_wr[g]),
            .wr_data(avs_writedata[CNT_W-1:0]),
            .rd_value(chan_rd[g]),
            .match(compare_match[g])
        );
    end

    // read decode; unmapped words, and the buffer redirected onto itself, read zero
    always_comb begin
        rd_mux = RST_WORD;
        if (eff_addr == OFS_CCV0) begin
            rd_mux = {16'h0000, chan_rd[0]};
        end else if (eff_addr == OFS_CCV1) begin
            rd_mux = {16'h0000, chan_rd[1]};
        end else if (eff_addr == OFS_CCV2) begin
            rd_mux = {16'h0000, chan_rd[2]};
        end else if (eff_addr == OFS_CCV3) begin
            rd_mux = {16'h0000, chan_rd[3]};
        end else if (eff_addr == OFS_IRMP) begin
            rd_mux = {30'h0000_0000, q.remap};
        end else if (eff_addr == OFS_BCFG) begin
            rd_mux = {19'h0_0000, q.bcount, 3'h0, q.bstart};
        end else begin
            rd_mux = RST_WORD;
        end
    end

    // bus handshake, register writes and the channel 0 input selector
    always_comb begin
        d = q;
        case (q.state)
            BUS_IDLE: begin
                if (req) begin
                    // answer one cycle after the request is seen
                    d.state = BUS_ACK;
                    d.waitreq = 1'b0;
                    d.rdata = avs_read ? rd_mux : q.rdata;
                end
            end
            BUS_ACK: begin
                d.state = BUS_IDLE;
                d.waitreq = 1'b1;
            end
            default: begin
                d.state = BUS_IDLE;
                d.waitreq = 1'b1;
            end
        endcase
        if (wr_ok) begin
            // reserved bits are simply not stored, so they read back as zero
            if (eff_addr == OFS_IRMP) begin
                d.remap = avs_writedata[REMAP_W-1:0];
            end else if (eff_addr == OFS_BCFG) begin
                d.bstart = avs_writedata[BCFG_START_MSB:BCFG_START_LSB];
                d.bcount = avs_writedata[BCFG_COUNT_MSB:BCFG_COUNT_LSB];
            end
        end
        // the sources are asynchronous to the timer in a real part; here they are
        // taken as synchronous and only registered once
        case (q.remap)
            SEL_GPIO: d.ch0in = pin_gpio_ch0;
            SEL_LOW_CRYSTAL: d.ch0in = low_speed_crystal;
            SEL_HIGH_CRYSTAL_DIV128: d.ch0in = high_speed_crystal_div128;
            SEL_CKOUT: d.ch0in = clock_output_selection;
            default: d.ch0in = pin_gpio_ch0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q.state <= BUS_IDLE;
            q.waitreq <= 1'b1;
            q.rdata <= RST_WORD;
            q.remap <= RST_REMAP;
            q.bstart <= RST_FIELD5;
            q.bcount <= RST_FIELD5;
            q.ch0in <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign avs_readdata = q.rdata;
    assign avs_waitrequest = q.waitreq;
    assign chan0_input = q.ch0in;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // a request seen idle is answered next cycle, then the slave stalls again
    sequence s_req_taken;
        (q.state == BUS_IDLE) && req;
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    property p_handshake;
        s_req_taken |=> s_answer;
    endproperty
    a_bus_handshake: assert property (p_handshake)
        else $error("waitrequest handshake broken");

    a_count_field: assert property (wr_ok && eff_addr == OFS_BCFG
        |=> q.bcount == $past(avs_writedata[12:8]))
        else $error("transfer count field not stored");

    a_start_field: assert property (wr_ok && eff_addr == OFS_BCFG
        |=> q.bstart == $past(avs_writedata[4:0]))
        else $error("start offset field not stored");

    a_first_target: assert property (burst_index == 5'h00
        |-> burst_target == OFS_CTL0 + {1'b0, q.bstart, 2'b00})
        else $error("first buffer access misdirected");

    a_second_word: assert property (step && burst_index == 5'h00
        && q.bcount != 5'h00 && !(wr_ok && eff_addr == OFS_BCFG)
        |=> burst_target == $past(burst_target) + WORD_BYTES)
        else $error("second buffer access not one word on");

    a_redirect_read: assert property ((q.state == BUS_IDLE) && avs_read
        && avs_address == OFS_BBUF && burst_target == OFS_IRMP
        |=> avs_readdata == {30'h0000_0000, $past(q.remap)})
        else $error("buffer read not redirected");

    a_partial_refused: assert property (commit && avs_write && avs_byteenable != BE_FULL
        |=> $stable(q.remap) && $stable(q.bstart) && $stable(q.bcount))
        else $error("partial write took effect");

    a_remap_low: assert property (q.remap == SEL_LOW_CRYSTAL && $stable(q.remap)
        |=> chan0_input == $past(low_speed_crystal))
        else $error("channel 0 input select wrong");

    // the other three selections, each held steady for one edge before it is judged
    a_remap_gpio: assert property (!reset && q.remap == SEL_GPIO && $stable(q.remap)
        |=> chan0_input == $past(pin_gpio_ch0))
        else $error("channel 0 pin input not selected");

    a_remap_high: assert property (q.remap == SEL_HIGH_CRYSTAL_DIV128 && $stable(q.remap)
        |=> chan0_input == $past(high_speed_crystal_div128))
        else $error("channel 0 divided crystal not selected");

    a_remap_clkout: assert property (q.remap == SEL_CKOUT && $stable(q.remap)
        |=> chan0_input == $past(clock_output_selection))
        else $error("channel 0 clock output not selected");

    // a remap write stores the two select bits
    a_remap_store: assert property (wr_ok && eff_addr == OFS_IRMP
        |=> q.remap == $past(avs_writedata[1:0]))
        else $error("remap select not stored");

    // a taken read shows its data in the ack cycle and still holds it one edge later
    sequence s_read_taken;
        (q.state == BUS_IDLE) && avs_read;
    endsequence
    sequence s_read_held;
        !avs_waitrequest ##1 $stable(avs_readdata);
    endsequence
    a_read_held: assert property (s_read_taken |=> s_read_held)
        else $error("read data did not stand through the ack");

    // read data change only when a read is taken, so a stale word is never refreshed
    a_rdata_stands: assert property (!((q.state == BUS_IDLE) && avs_read)
        |=> $stable(avs_readdata))
        else $error("read data changed without a read");

    // waitrequest drops for one cycle only, so a held request is never taken twice
    a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

    // with no request the slave keeps stalling
    a_idle_stall: assert property ((q.state == BUS_IDLE) && !req |=> avs_waitrequest)
        else $error("waitrequest dropped without a request");

    // a direct write to channel 1 in output mode with no shadow reads back at once
    a_chan_write: assert property (wr_ok && eff_addr == OFS_CCV1
        && !chan_input_mode[1] && !chan_shadow_en[1]
        |=> chan_rd[1] == $past(avs_writedata[15:0]))
        else $error("channel 1 write lost");

    // config reads back its two fields and zero in every reserved bit
    a_config_read: assert property ((q.state == BUS_IDLE) && avs_read
        && eff_addr == OFS_BCFG
        |=> avs_readdata == {19'h0_0000, $past(q.bcount), 3'h0, $past(q.bstart)})
        else $error("burst config read back wrong");

    // after the final index the next buffer access lands on the start word again
    a_wrap_target: assert property (step && burst_index == q.bcount
        && !(wr_ok && eff_addr == OFS_BCFG)
        |=> burst_target == OFS_CTL0 + {1'b0, q.bstart, 2'b00})
        else $error("burst did not return to the start word");

    // every buffer step happens in an ack cycle, once per access
    a_step_acked: assert property (step |-> !avs_waitrequest)
        else $error("transfer index stepped outside an ack");

endmodule // tdb_top

/* bench/tdb_bus_master.sv */
// tdb_bus_master: processor or DMA master on the Avalon-MM slave port of the register slice.
// assumes: one clock, the slave acks each access by dropping waitrequest for one cycle.
`timescale 1ns/10ps
module tdb_bus_master (
    input wire logic clk,
    output logic [tdb_pkg::ADDR_W-1:0] address,
    output logic read,
    output logic write,
    output logic [tdb_pkg::DATA_W-1:0] writedata,
    output logic [tdb_pkg::BE_W-1:0] byteenable,
    input wire logic [tdb_pkg::DATA_W-1:0] readdata,
    input wire logic waitrequest
);
    import tdb_pkg::*;

    // bus idle at time zero
    initial begin
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h5a5a_a5a5;
        byteenable = BE_FULL;
    end

    // one word access; no cycle count is assumed, the bench watchdog ends a hang
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic [BE_W-1:0] be,
                        output logic [DATA_W-1:0] q);
        @(posedge clk);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= d;
        byteenable <= be;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        // released data lines flip so a stale word is never mistaken for a fresh one
        writedata <= ~d;
    endtask
endmodule // tdb_bus_master

/* bench/tb.sv */
// tb: self-checking bench for the capture/compare and burst register slice.
// assumes: timer core inputs are driven here; a master model issues all bus accesses.
`timescale 1ns/10ps
module tb;
    import tdb_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] address;
    logic read, write;
    logic [DATA_W-1:0] writedata, readdata;
    logic [BE_W-1:0] byteenable;
    logic waitrequest;
    logic [CNT_W-1:0] counter_value = 16'h0000;
    logic update_event = 1'b0;
    logic [NCHAN-1:0] chan_input_mode = 4'h0;
    logic [NCHAN-1:0] chan_shadow_en = 4'h0;
    logic [NCHAN-1:0] capture_event = 4'h0;
    logic [3:0] src = 4'h0;
    logic [NCHAN-1:0] compare_match;
    logic chan0_input;
    int n_errors = 0;
    int checked = 0;

    // 125 MHz
    always #4 clk = ~clk;

    tdb_bus_master mst (.clk(clk), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest));

    tdb_top dut (.clk(clk), .reset(reset), .avs_address(address), .avs_read(read),
        .avs_write(write), .avs_writedata(writedata), .avs_byteenable(byteenable),
        .avs_readdata(readdata), .avs_waitrequest(waitrequest),
        .counter_value(counter_value), .update_event(update_event),
        .chan_input_mode(chan_input_mode), .chan_shadow_en(chan_shadow_en),
        .capture_event(capture_event), .pin_gpio_ch0(src[0]), .low_speed_crystal(src[1]),
        .high_speed_crystal_div128(src[2]), .clock_output_selection(src[3]),
        .compare_match(compare_match), .chan0_input(chan0_input));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] q;
        mst.xfer(1'b1, a, d, BE_FULL, q);
    endtask

    // lanes other than all four exercise the slave's refusal of torn writes
    task automatic wr_lanes(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                            input logic [BE_W-1:0] be);
        logic [DATA_W-1:0] q;
        mst.xfer(1'b1, a, d, be, q);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q);
        mst.xfer(1'b0, a, 32'h0000_0000, BE_FULL, q);
    endtask

    // let a change ripple through the registered outputs, then sample off the edge
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic t_reset_values();
        logic [7:0] ofs [7] = '{OFS_CCV0, OFS_CCV1, OFS_CCV2, OFS_CCV3, OFS_IRMP, OFS_BCFG,
                                8'h10};
        logic [31:0] q;
        foreach (ofs[i]) begin
            rd(ofs[i], q);
            chk(q, RST_WORD, "reset value");
        end
        $display("test reset_values done");
    endtask

    task automatic t_compare_direct();
        logic [31:0] q;
        wr(OFS_CCV1, 32'h0000_4321);
        rd(OFS_CCV1, q);
        chk(q, 32'h0000_4321, "ch1 readback");
        @(posedge clk);
        counter_value <= 16'h4321;
        settle();
        chk(compare_match[1], 1'b1, "ch1 match");
        @(posedge clk);
        counter_value <= 16'h4322;
        settle();
        chk(compare_match[1], 1'b0, "ch1 no match");
        $display("test compare_direct done");
    endtask

    task automatic t_compare_shadow();
        logic [31:0] q;
        @(posedge clk);
        chan_shadow_en <= 4'h4;
        counter_value <= 16'h0777;
        wr(OFS_CCV2, 32'h0000_0777);
        settle();
        chk(compare_match[2], 1'b0, "ch2 before update");
        @(posedge clk);
        update_event <= 1'b1;
        @(posedge clk);
        update_event <= 1'b0;
        settle();
        chk(compare_match[2], 1'b1, "ch2 after update");
        rd(OFS_CCV2, q);
        chk(q, 32'h0000_0777, "ch2 readback");
        $display("test compare_shadow done");
    endtask

    task automatic t_capture();
        logic [31:0] q;
        @(posedge clk);
        chan_input_mode <= 4'h1;
        counter_value <= 16'h1234;
        capture_event <= 4'h1;
        @(posedge clk);
        capture_event <= 4'h0;
        counter_value <= 16'h5678;
        rd(OFS_CCV0, q);
        chk(q, 32'h0000_1234, "ch0 capture");
        wr(OFS_CCV0, 32'h0000_aaaa);
        rd(OFS_CCV0, q);
        chk(q, 32'h0000_1234, "ch0 write in input mode");
        @(posedge clk);
        chan_input_mode <= 4'h0;
        $display("test capture done");
    endtask

    task automatic t_remap();
        logic [31:0] q;
        for (int s = 0; s < 4; s++) begin
            wr(OFS_IRMP, 32'(s));
            @(posedge clk);
            src <= 4'h1 << s;
            settle();
            chk(chan0_input, 1'b1, "remap selected high");
            @(posedge clk);
            src <= ~(4'h1 << s);
            settle();
            chk(chan0_input, 1'b0, "remap selected low");
        end
        // a one-lane write is dropped whole, the last select stays
        wr_lanes(OFS_IRMP, 32'h0000_0000, 4'h1);
        rd(OFS_IRMP, q);
        chk(q, 32'h0000_0003, "partial write dropped");
        $display("test remap done");
    endtask

    task automatic t_burst();
        logic [31:0] q;
        logic [7:0] ofs [4] = '{OFS_CCV0, OFS_CCV1, OFS_CCV2, OFS_CCV3};
        // start 13 lands on the channel 0 value word, count 3 gives four words
        wr(OFS_BCFG, 32'h0000_030d);
        rd(OFS_BCFG, q);
        chk(q, 32'h0000_030d, "burst config");
        for (int i = 0; i < 4; i++) wr(OFS_BBUF, 32'h0000_1111 * (i + 1));
        foreach (ofs[i]) begin
            rd(ofs[i], q);
            chk(q, 32'h0000_1111 * (i + 1), "burst target");
        end
        wr(OFS_BBUF, 32'h0000_5555);
        rd(OFS_CCV0, q);
        chk(q, 32'h0000_5555, "burst wrap");
        rd(OFS_BBUF, q);
        chk(q, 32'h0000_2222, "burst read target");
        rd(OFS_BBUF, q);
        chk(q, 32'h0000_3333, "burst third word");
        rd(OFS_BBUF, q);
        chk(q, 32'h0000_4444, "burst last word");
        // start 20 is the remap word; count 0 keeps a one-word burst on it
        wr(OFS_BCFG, 32'h0000_0014);
        rd(OFS_BBUF, q);
        chk(q, 32'h0000_0003, "single word burst");
        rd(OFS_BBUF, q);
        chk(q, 32'h0000_0003, "single word wrap");
        $display("test burst done");
    endtask

    task automatic results();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // all tests take well under a thousand cycles; twenty thousand means a hang
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        results();
    end

    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t_reset_values();
        t_compare_direct();
        t_compare_shadow();
        t_capture();
        t_remap();
        t_burst();
        results();
    end
endmodule // tb
